// [rtl/tmr_pkg.sv]
// Constants and types shared by the 16-bit capture/one-shot timer.
package tmr_pkg;
    // ==========================================================
    // Widths and counter values
    localparam int          CNT_W    = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hffff;
    localparam logic [15:0] CAP_RST  = 16'h0000;
    localparam int          PSC_W    = 4;
    localparam logic [1:0]  EV_START = 2'h2;
    // ==========================================================
    // Counter operating modes
    localparam logic [1:0] MODE_STOP      = 2'h0;
    localparam logic [1:0] MODE_FREE      = 2'h1;
    localparam logic [1:0] MODE_CLR_EDGE  = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
    // ==========================================================
    // Valid edge codes of a trigger pin (edge_select_hi, edge_select_lo)
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // ==========================================================
    // One-shot sequencer states
    typedef enum logic [2:0] {
        OS_IDLE  = 3'b001,
        OS_LEAD  = 3'b010,
        OS_PULSE = 3'b100
    } tmr_os_t;
endpackage

// [rtl/tmr_timer16.sv]
// 16-bit timer/event counter with two capture/compare registers, one-shot and PPG output.
// Notes on behaviour
// - One-shot works in free-running or clear-on-trigger-A mode, never clear-on-match-A.
// - In clear-on-trigger-A mode a trigger A edge still clears and restarts the counter during software one-shot.
// - Overflow flag sets when the counter wraps from all ones to zero.
// - Clearing overflow before the next count tick after a wrap is ignored.
// - Capture wins over a coincident read or write; capture at stop is undefined.
// - Source select set and both edges on trigger A: no capture into register A.
// - Source select set: trigger B edge raises match interrupt A without capturing.
// - Capture happens at count clock fall; its interrupt at the following rise.
// - A register in compare mode does not capture on a trigger.
// - The counter keeps counting while inversion and interrupt are disabled.
// - Rewriting register B without the safe sequence may toggle the output each time.
// - A pin level differing from reset or stop level gives an immediate edge at start.
// - Noise filter needs the new level sampled twice; sample clock depends on use.
// - Event counter mode starts counting only after two valid edges.
// - PPG gives period register A plus one, high time register B plus one counts.
// - The software one-shot trigger clears itself and always reads back zero.
// - One-shot goes active at the smaller register match, inactive at the larger.
module tmr_timer16
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic                   I_CLK_SYS,
    input  wire logic                   I_RST_N,
    // Mode and prescaler control
    input  wire logic [1:0]             I_MODE,
    input  wire logic [1:0]             I_PRESCALER_SEL,
    input  wire logic                   I_EVENT_COUNT,
    input  wire logic                   I_ONESHOT_EN,
    input  wire logic                   I_PPG_EN,
    // Trigger edge and capture configuration
    input  wire logic [1:0]             I_EDGE_SEL_A,
    input  wire logic [1:0]             I_EDGE_SEL_B,
    input  wire logic                   I_CAPCMP_A_IS_CAP,
    input  wire logic                   I_CAPCMP_B_IS_CAP,
    input  wire logic                   I_CAPTURE_SOURCE_SEL,
    // Output control
    input  wire logic                   I_INVERT_ON_MATCH_A_EN,
    input  wire logic                   I_INVERT_ON_MATCH_B_EN,
    input  wire logic                   I_SW_ONESHOT_TRIGGER,
    input  wire logic                   I_OVERFLOW_CLEAR,
    // Register writes
    input  wire logic                   I_CAPCMP_A_WR,
    input  wire logic                   I_CAPCMP_B_WR,
    input  wire logic [tmr_pkg::CNT_W-1:0] I_WR_DATA,
    // Pins
    input  wire logic                   I_TRIGGER_INPUT_A,
    input  wire logic                   I_TRIGGER_INPUT_B,
    // Status and registers
    output logic [tmr_pkg::CNT_W-1:0]   O_MAIN_COUNTER,
    output logic [tmr_pkg::CNT_W-1:0]   O_CAPCMP_A,
    output logic [tmr_pkg::CNT_W-1:0]   O_CAPCMP_B,
    output logic                        O_OVERFLOW_FLAG,
    output logic                        O_SW_ONESHOT_TRIGGER,
    output logic                        O_MATCH_IRQ_A,
    output logic                        O_MATCH_IRQ_B,
    output logic                        O_TIMER_OUTPUT_PIN
);
    import tmr_pkg::*;
    // ==========================================================
    // Helpers
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            EDGE_RISE: edge_hit = r;
            EDGE_FALL: edge_hit = f;
            EDGE_BOTH: edge_hit = r | f;
            default:   edge_hit = 1'b0;
        endcase
    endfunction
    function automatic logic [PSC_W-1:0] psc_top(input logic [1:0] sel);
        psc_top = PSC_W'((5'h2 << sel) - 5'h1);
    endfunction
    // ==========================================================
    // State
    logic [PSC_W-1:0] psc_q, psc_d;
    logic [1:0]       sync1_q, sync2_q, smp_q, smp_d, lvl_q, lvl_d;
    logic [1:0]       ev_cnt_q, ev_cnt_d;
    logic [15:0]      cnt_q, cnt_d, cap_a_q, cap_a_d, cap_b_q, cap_b_d;
    logic             ovf_q, ovf_d, ovf_hold_q, ovf_hold_d;
    logic             ost_pend_q, ost_pend_d;
    logic             capa_pend_q, capa_pend_d, capb_pend_q, capb_pend_d;
    logic             irqa_pend_q, irqa_pend_d, irqb_pend_q, irqb_pend_d;
    logic             irq_a_q, irq_a_d, irq_b_q, irq_b_d, out_q, out_d;
    tmr_os_t          os_q, os_d;
    logic [1:0]       rise_e, fall_e;
    logic             run, rise_tick, fall_tick, a_edge, a_rev, b_edge, cnt_tick, clr_start;
    logic             os_ok, match_a, match_b, lead_hit, trail_hit, ovf_evt;
    // ==========================================================
    // Count clock and pin noise filter
    assign run       = (I_MODE != MODE_STOP);
    assign rise_tick = run && (psc_q == psc_top(I_PRESCALER_SEL));
    assign fall_tick = run && (psc_q == (psc_top(I_PRESCALER_SEL) >> 1));
    always_comb begin
        psc_d  = run ? (rise_tick ? '0 : psc_q + 1'b1) : '0;
        smp_d  = smp_q;
        lvl_d  = lvl_q;
        rise_e = 2'b00;
        fall_e = 2'b00;
        for (int i = 0; i < 2; i++) begin
            // Filter is frozen while stopped, so the level held at reset or stop is compared at start.
            if (run && ((i == 0 && I_EVENT_COUNT) || rise_tick)) begin
                smp_d[i] = sync2_q[i];
                if (sync2_q[i] == smp_q[i] && sync2_q[i] != lvl_q[i]) begin
                    lvl_d[i]  = sync2_q[i];
                    rise_e[i] = sync2_q[i];
                    fall_e[i] = !sync2_q[i];
                end
            end
        end
    end
    assign a_edge = edge_hit(I_EDGE_SEL_A, rise_e[0], fall_e[0]);
    assign a_rev  = (I_EDGE_SEL_A == EDGE_BOTH) ? 1'b0 : edge_hit(I_EDGE_SEL_A, fall_e[0], rise_e[0]);
    assign b_edge = edge_hit(I_EDGE_SEL_B, rise_e[1], fall_e[1]);
    // ==========================================================
    // Counter, overflow and one-shot start
    assign os_ok     = I_ONESHOT_EN && (I_MODE == MODE_FREE || I_MODE == MODE_CLR_EDGE);
    assign cnt_tick  = I_EVENT_COUNT ? (run && a_edge && ev_cnt_q == EV_START) : rise_tick;
    assign clr_start = run && !I_EVENT_COUNT &&
                       ((I_MODE == MODE_CLR_EDGE && a_edge) || (ost_pend_q && rise_tick));
    assign ovf_evt   = cnt_tick && !clr_start && (cnt_q == CNT_MAX);
    assign match_a   = cnt_tick && !I_CAPCMP_A_IS_CAP && (cnt_q == cap_a_q);
    assign match_b   = cnt_tick && !I_CAPCMP_B_IS_CAP && (cnt_q == cap_b_q);
    assign lead_hit  = (cap_b_q < cap_a_q) ? match_b : match_a;
    assign trail_hit = (cap_b_q < cap_a_q) ? match_a : match_b;
    always_comb begin
        cnt_d = cnt_q;
        if (!run || clr_start) begin
            cnt_d = CNT_ZERO;
        end else if (cnt_tick) begin
            cnt_d = (I_MODE == MODE_CLR_MATCH && cnt_q == cap_a_q) ? CNT_ZERO : cnt_q + 1'b1;
        end
        ev_cnt_d = (run && I_EVENT_COUNT) ? ev_cnt_q : 2'h0;
        if (run && I_EVENT_COUNT && a_edge && ev_cnt_q != EV_START) begin
            ev_cnt_d = ev_cnt_q + 1'b1;
        end
        // The flag is forced until the next count tick, so an early clear is lost.
        ovf_hold_d = run && (ovf_evt || (ovf_hold_q && !cnt_tick));
        ovf_d      = ovf_evt || ovf_hold_q || (ovf_q && !I_OVERFLOW_CLEAR);
        // The trigger is held internally only until the next count tick; it always reads as zero.
        ost_pend_d = run && os_ok && (I_SW_ONESHOT_TRIGGER || (ost_pend_q && !rise_tick));
    end
    // ==========================================================
    // Capture, interrupts and registers
    always_comb begin
        capa_pend_d = run && I_CAPCMP_A_IS_CAP &&
                      ((I_CAPTURE_SOURCE_SEL ? a_rev : b_edge) || (capa_pend_q && !fall_tick));
        capb_pend_d = run && I_CAPCMP_B_IS_CAP && (a_edge || (capb_pend_q && !fall_tick));
        irqa_pend_d = run && ((fall_tick && capa_pend_q) || (I_CAPTURE_SOURCE_SEL && b_edge) ||
                              (irqa_pend_q && !rise_tick));
        irqb_pend_d = run && ((fall_tick && capb_pend_q) || (irqb_pend_q && !rise_tick));
        irq_a_d     = match_a || (irqa_pend_q && rise_tick);
        irq_b_d     = match_b || (irqb_pend_q && rise_tick);
        cap_a_d     = cap_a_q;
        cap_b_d     = cap_b_q;
        if (fall_tick && capa_pend_q) begin
            cap_a_d = cnt_q;
        end else if (I_CAPCMP_A_WR) begin
            cap_a_d = I_WR_DATA;
        end
        if (fall_tick && capb_pend_q) begin
            cap_b_d = cnt_q;
        end else if (I_CAPCMP_B_WR) begin
            cap_b_d = I_WR_DATA;
        end
    end
    // ==========================================================
    // Timer output
    always_comb begin
        out_d = out_q;
        os_d  = os_q;
        if (!run) begin
            out_d = 1'b0;
            os_d  = OS_IDLE;
        end else if (clr_start && os_ok) begin
            out_d = 1'b0;
            os_d  = OS_LEAD;
        end else begin
            case (os_q)
                OS_IDLE: begin
                    if (I_PPG_EN) begin
                        if (match_a) begin
                            out_d = 1'b1;
                        end else if (match_b) begin
                            out_d = 1'b0;
                        end
                    end else if (!os_ok) begin
                        // With inversion B enabled, each match of register B toggles, including one made by a rewrite.
                        out_d = out_q ^ (match_a && I_INVERT_ON_MATCH_A_EN)
                                      ^ (match_b && I_INVERT_ON_MATCH_B_EN);
                    end
                end
                OS_LEAD: begin
                    if (lead_hit) begin
                        out_d = 1'b1;
                        os_d  = OS_PULSE;
                    end
                end
                OS_PULSE: begin
                    if (trail_hit) begin
                        out_d = 1'b0;
                        os_d  = OS_IDLE;
                    end
                end
                default: os_d = OS_IDLE;
            endcase
        end
    end
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            psc_q <= '0;  sync1_q <= 2'b00;  sync2_q <= 2'b00;  smp_q <= 2'b00;  lvl_q <= 2'b00;
            ev_cnt_q <= 2'h0;  cnt_q <= CNT_ZERO;  cap_a_q <= CAP_RST;  cap_b_q <= CAP_RST;
            ovf_q <= 1'b0;  ovf_hold_q <= 1'b0;  ost_pend_q <= 1'b0;  capa_pend_q <= 1'b0;
            capb_pend_q <= 1'b0;  irqa_pend_q <= 1'b0;  irqb_pend_q <= 1'b0;
            irq_a_q <= 1'b0;  irq_b_q <= 1'b0;  out_q <= 1'b0;  os_q <= OS_IDLE;
        end else begin
            psc_q <= psc_d;  sync1_q <= {I_TRIGGER_INPUT_B, I_TRIGGER_INPUT_A};  sync2_q <= sync1_q;
            smp_q <= smp_d;  lvl_q <= lvl_d;  ev_cnt_q <= ev_cnt_d;  cnt_q <= cnt_d;
            cap_a_q <= cap_a_d;  cap_b_q <= cap_b_d;  ovf_q <= ovf_d;  ovf_hold_q <= ovf_hold_d;
            ost_pend_q <= ost_pend_d;  capa_pend_q <= capa_pend_d;  capb_pend_q <= capb_pend_d;
            irqa_pend_q <= irqa_pend_d;  irqb_pend_q <= irqb_pend_d;
            irq_a_q <= irq_a_d;  irq_b_q <= irq_b_d;  out_q <= out_d;  os_q <= os_d;
        end
    end
    assign O_MAIN_COUNTER       = cnt_q;
    assign O_CAPCMP_A           = cap_a_q;
    assign O_CAPCMP_B           = cap_b_q;
    assign O_OVERFLOW_FLAG      = ovf_q;
    assign O_SW_ONESHOT_TRIGGER = 1'b0;
    assign O_MATCH_IRQ_A        = irq_a_q;
    assign O_MATCH_IRQ_B        = irq_b_q;
    assign O_TIMER_OUTPUT_PIN   = out_q;
    // ==========================================================
    // Assertions
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    property p_ovf_wrap;
        ovf_evt |=> O_OVERFLOW_FLAG && O_MAIN_COUNTER == CNT_ZERO;
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow flag not set at wrap");
    property p_ovf_early_clear;
        ovf_hold_q && I_OVERFLOW_CLEAR |=> O_OVERFLOW_FLAG;
    endproperty
    a_ovf_early_clear: assert property (p_ovf_early_clear) else $error("early overflow clear took effect");
    property p_cap_then_irq;
        fall_tick && capa_pend_q |=> O_CAPCMP_A == $past(cnt_q) ##[0:16] O_MATCH_IRQ_A;
    endproperty
    a_cap_then_irq: assert property (p_cap_then_irq) else $error("capture or its interrupt missing");
    property p_cmp_no_cap;
        !I_CAPCMP_A_IS_CAP && !I_CAPCMP_A_WR |=> $stable(O_CAPCMP_A);
    endproperty
    a_cmp_no_cap: assert property (p_cmp_no_cap) else $error("compare register captured");
    property p_both_no_cap;
        I_CAPTURE_SOURCE_SEL && I_EDGE_SEL_A == EDGE_BOTH && !capa_pend_q |=> !capa_pend_q;
    endproperty
    a_both_no_cap: assert property (p_both_no_cap) else $error("capture with both edges selected");
    property p_b_irq;
        I_CAPTURE_SOURCE_SEL && b_edge && I_MODE == $past(I_MODE) |-> ##[1:17] O_MATCH_IRQ_A;
    endproperty
    a_b_irq: assert property (p_b_irq) else $error("trigger B gave no interrupt A");
    property p_os_mode;
        os_q == OS_IDLE && !os_ok |=> os_q == OS_IDLE;
    endproperty
    a_os_mode: assert property (p_os_mode) else $error("one-shot started in wrong mode");
    property p_ext_restart;
        run && I_MODE == MODE_CLR_EDGE && !I_EVENT_COUNT && a_edge |=> O_MAIN_COUNTER == CNT_ZERO;
    endproperty
    a_ext_restart: assert property (p_ext_restart) else $error("trigger A edge did not restart");
    property p_ev_start;
        run && I_EVENT_COUNT && ev_cnt_q != EV_START && $past(ev_cnt_q) != EV_START |-> O_MAIN_COUNTER == CNT_ZERO;
    endproperty
    a_ev_start: assert property (p_ev_start) else $error("event count began too early");
    property p_filter;
        lvl_q[0] != $past(lvl_q[0]) |-> $past(smp_q[0]) == lvl_q[0] && $past(sync2_q[0]) == lvl_q[0];
    endproperty
    a_filter: assert property (p_filter) else $error("level accepted on one sample");
    property p_os_lead;
        run && !clr_start && os_q == OS_LEAD && lead_hit |=> O_TIMER_OUTPUT_PIN ##1 os_q == OS_PULSE;
    endproperty
    a_os_lead: assert property (p_os_lead) else $error("one-shot did not go active");
    property p_ppg_rise;
        run && !clr_start && os_q == OS_IDLE && I_PPG_EN && match_a |=> O_TIMER_OUTPUT_PIN;
    endproperty
    a_ppg_rise: assert property (p_ppg_rise) else $error("PPG period start missing");
    c_overflow: cover property (ovf_evt);
    c_capture_a: cover property (fall_tick && capa_pend_q ##[1:16] O_MATCH_IRQ_A);
    c_oneshot: cover property (os_q == OS_LEAD ##[1:300] os_q == OS_PULSE);
    c_ppg: cover property (I_PPG_EN && match_a);
endmodule

// [tb/tmr_pin_model.sv]
// Model of the trigger pin sources and of the load on the timer output pin.
module tmr_pin_model (
    // Clock
    input  wire logic i_clk,
    // Output pin under observation
    input  wire logic i_pin,
    // Trigger pins
    output logic      o_trig_a,
    output logic      o_trig_b
);
    timeunit 1ns;
    timeprecision 1ns;
    int   high_cnt;
    int   rise_cnt;
    logic pin_q;
    initial begin
        o_trig_a = 1'b0;
        o_trig_b = 1'b0;
        high_cnt = 0;
        rise_cnt = 0;
        pin_q    = 1'b0;
    end
    // ==========================================================
    // Output load meter
    // The load counts high cycles and rising edges, so pulse width and period need no edge timing.
    always @(posedge i_clk) begin
        if (i_pin === 1'b1) high_cnt++;
        if (i_pin === 1'b1 && pin_q !== 1'b1) rise_cnt++;
        pin_q <= i_pin;
    end
    task automatic clr_meter();
        high_cnt = 0;
        rise_cnt = 0;
    endtask
    // ==========================================================
    // Trigger sources
    // Each level is held for the whole span before the next change.
    task automatic level_a(input logic v, input int hold);
        @(negedge i_clk) o_trig_a = v;
        repeat (hold) @(negedge i_clk);
    endtask
    task automatic level_b(input logic v, input int hold);
        @(negedge i_clk) o_trig_b = v;
        repeat (hold) @(negedge i_clk);
    endtask
    // The high phase lasts 13 cycles and the low phase 12, longer than two count clocks at the slowest prescaler used.
    task automatic pulse_a();
        level_a(1'b1, 12);
        level_a(1'b0, 12);
    endtask
    task automatic pulse_b();
        level_b(1'b1, 12);
        level_b(1'b0, 12);
    endtask
endmodule

// [tb/tb.sv]
// Self-checking testbench for the 16-bit capture/one-shot timer.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ev = 1'b0, os_en = 1'b0, ppg_en = 1'b0, a_cap = 1'b0, b_cap = 1'b0;
    logic src_sel = 1'b0, inv_a = 1'b0, inv_b = 1'b0, sw_trig = 1'b0, ovf_clr = 1'b0, wr_a = 1'b0, wr_b = 1'b0;
    logic [1:0]  mode = MODE_STOP, psc = 2'h0, es_a = 2'h2, es_b = 2'h2;
    logic [15:0] wr_data = 16'h0000, cnt, ra, rb;
    logic        trig_a, trig_b, ovf, sw_rd, irq_a, irq_b, pin;
    int          n_errors = 0, checks = 0, irq_cnt = 0, irqb_cnt = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (irq_a === 1'b1) irq_cnt++;
    always @(posedge clk) if (irq_b === 1'b1) irqb_cnt++;
    tmr_timer16 tmr_timer16_i (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_MODE(mode), .I_PRESCALER_SEL(psc), .I_EVENT_COUNT(ev),
        .I_ONESHOT_EN(os_en), .I_PPG_EN(ppg_en), .I_EDGE_SEL_A(es_a), .I_EDGE_SEL_B(es_b),
        .I_CAPCMP_A_IS_CAP(a_cap), .I_CAPCMP_B_IS_CAP(b_cap), .I_CAPTURE_SOURCE_SEL(src_sel),
        .I_INVERT_ON_MATCH_A_EN(inv_a), .I_INVERT_ON_MATCH_B_EN(inv_b), .I_SW_ONESHOT_TRIGGER(sw_trig),
        .I_OVERFLOW_CLEAR(ovf_clr), .I_CAPCMP_A_WR(wr_a), .I_CAPCMP_B_WR(wr_b), .I_WR_DATA(wr_data),
        .I_TRIGGER_INPUT_A(trig_a), .I_TRIGGER_INPUT_B(trig_b), .O_MAIN_COUNTER(cnt), .O_CAPCMP_A(ra),
        .O_CAPCMP_B(rb), .O_OVERFLOW_FLAG(ovf), .O_SW_ONESHOT_TRIGGER(sw_rd), .O_MATCH_IRQ_A(irq_a),
        .O_MATCH_IRQ_B(irq_b), .O_TIMER_OUTPUT_PIN(pin));
    tmr_pin_model tmr_pin_model_i (.i_clk(clk), .i_pin(pin), .o_trig_a(trig_a), .o_trig_b(trig_b));
    // ==========================================================
    // Tasks
    task automatic test_done();
        $display("tb: %0d checks, %0d errors", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic sel_b, input logic [15:0] d);
        @(negedge clk) {wr_b, wr_a, wr_data} = {sel_b, ~sel_b, d};
        @(negedge clk) {wr_b, wr_a} = 2'b00;
    endtask
    // Stopping between scenarios clears the counter, the output and the one-shot state.
    task automatic halt();
        mode = MODE_STOP;
        cyc(3);
    endtask
    // The software trigger is a single-cycle write; the pulse length is read from the load meter.
    task automatic shot(input logic [15:0] exp);
        tmr_pin_model_i.clr_meter();
        sw_trig = 1'b1;
        cyc(1);
        sw_trig = 1'b0;
        chk("sw trigger readback", 16'h0000, {15'h0000, sw_rd});
        cyc(40);
        chk("one-shot high cycles", exp, 16'(tmr_pin_model_i.high_cnt));
    endtask
    // ==========================================================
    // Watchdog
    initial begin
        #(4000 * 50);
        n_errors++;
        test_done();
    end
    // ==========================================================
    // Main sequence
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cyc(1);
        chk("counter after reset", 16'h0000, cnt);
        chk("capcmp a after reset", 16'h0000, ra);
        chk("capcmp b after reset", 16'h0000, rb);
        chk("flags after reset", 16'h0000, {11'h000, ovf, sw_rd, irq_a, irq_b, pin});
        // Pin already high at start counts as the first edge; two edges are consumed.
        tmr_pin_model_i.level_a(1'b1, 4);
        {es_a, ev} = {EDGE_RISE, 1'b1};
        mode = MODE_FREE;
        repeat (4) begin
            tmr_pin_model_i.level_a(1'b0, 6);
            tmr_pin_model_i.level_a(1'b1, 6);
        end
        chk("event count", 16'h0003, cnt);
        tmr_pin_model_i.level_a(1'b0, 6);
        halt();
        ev = 1'b0;
        wr(1'b0, 16'h0006);
        wr(1'b1, 16'h0002);
        {os_en, mode} = {1'b1, MODE_FREE};
        cyc(4);
        shot(16'h0008);
        wr(1'b0, 16'h0002);
        wr(1'b1, 16'h0006);
        // Compares are rewritten while counting with inversion off, so one count clock must pass.
        cyc(2);
        shot(16'h0008);
        halt();
        wr(1'b0, 16'h0006);
        wr(1'b1, 16'h0002);
        mode = MODE_CLR_EDGE;
        cyc(4);
        tmr_pin_model_i.clr_meter();
        tmr_pin_model_i.pulse_a();
        cyc(30);
        chk("external one-shot high cycles", 16'h0008, 16'(tmr_pin_model_i.high_cnt));
        halt();
        mode = MODE_CLR_MATCH;
        cyc(4);
        shot(16'h0000);
        halt();
        // PPG at count clock /4: period 8 counts of 4 cycles, high 4 counts.
        {os_en, psc} = {1'b0, 2'h1};
        wr(1'b0, 16'h0007);
        wr(1'b1, 16'h0003);
        {ppg_en, mode} = {1'b1, MODE_CLR_MATCH};
        cyc(40);
        tmr_pin_model_i.clr_meter();
        irqb_cnt = 0;
        cyc(128);
        chk("ppg high cycles", 16'h0040, 16'(tmr_pin_model_i.high_cnt));
        chk("ppg periods", 16'h0004, 16'(tmr_pin_model_i.rise_cnt));
        chk("ppg irq b pulses", 16'h0004, 16'(irqb_cnt));
        halt();
        // Register A starts from zero so that a missing capture is seen.
        wr(1'b0, 16'h0000);
        {ppg_en, psc, a_cap, es_b} = {1'b0, 2'h0, 1'b1, EDGE_RISE};
        mode = MODE_FREE;
        cyc(10);
        irq_cnt = 0;
        tmr_pin_model_i.pulse_b();
        chk("capture irq pulses", 16'h0001, 16'(irq_cnt));
        chk("capture in range", 16'h0001, {15'h0000, ra != 16'h0000 && ra <= cnt});
        halt();
        wr(1'b0, 16'h0055);
        {src_sel, mode} = {1'b1, MODE_FREE};
        cyc(4);
        irq_cnt = 0;
        tmr_pin_model_i.pulse_b();
        chk("trigger b irq pulses", 16'h0001, 16'(irq_cnt));
        chk("capcmp a kept", 16'h0055, ra);
        wr(1'b1, 16'h0044);
        halt();
        es_a = EDGE_BOTH;
        mode = MODE_FREE;
        cyc(4);
        tmr_pin_model_i.pulse_a();
        chk("capcmp a both edges", 16'h0055, ra);
        chk("capcmp b compare mode", 16'h0044, rb);
        halt();
        test_done();
    end
endmodule
